// File: hdl/nvsp_host.sv
// Host controller driving the nonvolatile byte-wide static memory
// Behaviour
// - Strobe overlap held at least the write pulse width.
// - Address held unchanged through the whole write.
// - Write strobe held high for recovery before next cycle.
// - Data hold timed with the longer select-ended figure; recovery set by cycle time less write pulse.
// - Output enable kept high throughout writes.
// - Write data valid the setup time before and held after strobe rise.
// - One common minimum cycle period used for reads and writes.
// - Chip select parked high at least the lead time from the first idle cycle that sees supply fail.
// - After the down state ends on power return, strobes held high for the recovery wait.
// - Write timing rounded up; only the write pulse is padded, one cycle beyond its minimum.
module nvsp_host #(
    parameter int unsigned PD_CYCLES = nvsp_pkg::PD_CYC,
    parameter int unsigned PU_CYCLES = nvsp_pkg::PU_CYC
) (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          req_valid,
    input  wire nvsp_pkg::nvsp_req_type        req,
    output logic                               req_ready,
    output logic                               rsp_valid,
    output logic [nvsp_pkg::DATA_W-1:0]        rsp_rdata,
    input  wire logic                          power_fail,
    output logic                               power_ok,
    output nvsp_pkg::nvsp_pins_type            pins,
    input  wire logic [nvsp_pkg::DATA_W-1:0]   data_lines_i
);

    typedef enum logic [2:0] {
        NVSP_POWERUP, NVSP_IDLE, NVSP_READ, NVSP_WRITE, NVSP_HOLD, NVSP_RECOVER, NVSP_DOWN
    } nvsp_state_type;

    // ==================================================
    // State and counters
    nvsp_state_type                  state_q, state_d;
    logic [nvsp_pkg::CNT_W-1:0]      cnt_q, cnt_d;
    logic [nvsp_pkg::CNT_W-1:0]      fail_cnt_q;
    nvsp_pkg::nvsp_pins_type         pins_q, pins_d;
    logic                            ready_q, ready_d;
    logic                            rvalid_q, rvalid_d;
    logic [nvsp_pkg::DATA_W-1:0]     rdata_q, rdata_d;
    logic                            pok_q, pok_d;

    // ==================================================
    // Decode
    wire logic cnt_done   = (cnt_q == '0);
    wire logic start_ok   = req_valid & ready_q;
    wire logic [nvsp_pkg::CNT_W-1:0] cnt_dec = cnt_q - 20'h00001;
    // Read cycle padded to full cycle time
    wire logic [nvsp_pkg::CNT_W-1:0] rd_cnt =
        nvsp_pkg::CNT_W'(nvsp_pkg::CYC_CYC - 1);
    // Pulse padded by one cycle for protection circuitry slack
    wire logic [nvsp_pkg::CNT_W-1:0] wp_cnt =
        nvsp_pkg::CNT_W'(nvsp_pkg::WP_CYC);
    wire logic [nvsp_pkg::CNT_W-1:0] hold_cnt =
        nvsp_pkg::CNT_W'(nvsp_pkg::HOLD_CYC - 1);
    wire logic [nvsp_pkg::CNT_W-1:0] rec_cnt =
        nvsp_pkg::CNT_W'(nvsp_pkg::CYC_CYC - nvsp_pkg::WP_CYC - 1);
    wire logic [nvsp_pkg::CNT_W-1:0] pu_cnt = nvsp_pkg::CNT_W'(PU_CYCLES - 1);
    // Down state kept at least the lead time
    wire logic pd_reached = (fail_cnt_q >= nvsp_pkg::CNT_W'(PD_CYCLES));

    // ==================================================
    // Next-state logic
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_done ? cnt_q : cnt_dec;
        pins_d   = pins_q;
        ready_d  = 1'b0;
        rvalid_d = 1'b0;
        rdata_d  = rdata_q;
        pok_d    = pok_q;
        unique case (state_q)
            NVSP_POWERUP: begin
                // Strobes parked high during wait
                pins_d.chip_select_n   = 1'b1;
                pins_d.write_strobe_n  = 1'b1;
                pins_d.output_enable_n = 1'b1;
                pins_d.data_lines_oe   = 1'b0;
                if (cnt_done && !power_fail) begin
                    state_d = NVSP_IDLE;
                    ready_d = 1'b1;
                    pok_d   = 1'b1;
                end
            end
            NVSP_IDLE: begin
                ready_d = 1'b1;
                if (power_fail) begin
                    state_d = NVSP_DOWN;
                    ready_d = 1'b0;
                    pok_d   = 1'b0;
                end else if (start_ok) begin
                    ready_d             = 1'b0;
                    pins_d.byte_address = req.byte_address;
                    pins_d.chip_select_n = 1'b0;
                    if (req.write) begin
                        // Strobes fall together, output enable stays high
                        pins_d.write_strobe_n  = 1'b0;
                        pins_d.output_enable_n = 1'b1;
                        pins_d.data_lines_o    = req.wdata;
                        pins_d.data_lines_oe   = 1'b1;
                        cnt_d   = wp_cnt;
                        state_d = NVSP_WRITE;
                    end else begin
                        pins_d.write_strobe_n  = 1'b1;
                        pins_d.output_enable_n = 1'b0;
                        pins_d.data_lines_oe   = 1'b0;
                        cnt_d   = rd_cnt;
                        state_d = NVSP_READ;
                    end
                end
            end
            NVSP_READ: begin
                if (cnt_done) begin
                    // Sample while select and enable still low
                    rdata_d  = data_lines_i;
                    rvalid_d = 1'b1;
                    pins_d.chip_select_n   = 1'b1;
                    pins_d.output_enable_n = 1'b1;
                    state_d  = NVSP_IDLE;
                    ready_d  = !power_fail;
                end
            end
            NVSP_WRITE: begin
                // Address and data held; both strobes rise together
                if (cnt_done) begin
                    pins_d.chip_select_n  = 1'b1;
                    pins_d.write_strobe_n = 1'b1;
                    cnt_d   = hold_cnt;
                    state_d = NVSP_HOLD;
                end
            end
            NVSP_HOLD: begin
                if (cnt_done) begin
                    pins_d.data_lines_oe = 1'b0;
                    cnt_d   = rec_cnt;
                    state_d = NVSP_RECOVER;
                end
            end
            NVSP_RECOVER: begin
                if (cnt_done) begin
                    rvalid_d = 1'b1;
                    state_d  = NVSP_IDLE;
                    ready_d  = !power_fail;
                end
            end
            NVSP_DOWN: begin
                // Park every strobe high while supply is low
                pins_d.chip_select_n   = 1'b1;
                pins_d.write_strobe_n  = 1'b1;
                pins_d.output_enable_n = 1'b1;
                pins_d.data_lines_oe   = 1'b0;
                if (!power_fail && pd_reached) begin
                    cnt_d   = pu_cnt;
                    state_d = NVSP_POWERUP;
                end
            end
            default: state_d = NVSP_DOWN;
        endcase
    end

    // ==================================================
    // Registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q  <= NVSP_POWERUP;
            cnt_q    <= nvsp_pkg::CNT_W'(PU_CYCLES - 1);
            pins_q   <= '{byte_address: '0, chip_select_n: 1'b1, output_enable_n: 1'b1,
                          write_strobe_n: 1'b1, data_lines_o: '0, data_lines_oe: 1'b0};
            ready_q  <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= 8'h00;
            pok_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            pins_q   <= pins_d;
            ready_q  <= ready_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            pok_q    <= pok_d;
        end
    end

    // Cycles spent parked; a short supply dip seen in idle still parks the full lead time
    always_ff @(posedge clk) begin
        if (reset || state_q != NVSP_DOWN) begin
            fail_cnt_q <= '0;
        end else if (!pd_reached) begin
            fail_cnt_q <= fail_cnt_q + 20'h00001;
        end
    end

    // ==================================================
    // Outputs straight from flip-flops
    assign req_ready = ready_q;
    assign rsp_valid = rvalid_q;
    assign rsp_rdata = rdata_q;
    assign power_ok  = pok_q;
    assign pins      = pins_q;

endmodule

// File: hdl/nvsp_pkg.sv
// Package: timing constants, request carrier and pin bundle for the memory port host
package nvsp_pkg;

    localparam int unsigned CLK_PERIOD_PS = 5000;

    // Times in ns as printed
    localparam int unsigned CYCLE_TIME_NS           = 70;
    localparam int unsigned ADDRESS_TO_DATA_DELAY_NS = 70;
    localparam int unsigned SELECT_TO_DATA_DELAY_NS  = 70;
    localparam int unsigned OE_TO_DATA_DELAY_NS      = 35;
    localparam int unsigned WRITE_PULSE_NS           = 55;
    localparam int unsigned WRITE_DATA_SETUP_NS      = 30;
    localparam int unsigned WRITE_RECOVERY_NS        = 5;
    localparam int unsigned WRITE_RECOVERY_CS_NS     = 15;
    localparam int unsigned WRITE_DATA_HOLD_CS_NS    = 10;
    localparam int unsigned WRITE_TO_FLOAT_DELAY_NS  = 25;
    // Power sequencing times
    localparam int unsigned POWERDOWN_LEAD_TIME_US   = 20;
    localparam int unsigned POWERUP_WAIT_TIME_MS     = 2;
    localparam int unsigned POWERUP_WAIT_MAX_MS      = 125;

    // Least times round up to whole cycles
    localparam int unsigned READ_CYC = (ADDRESS_TO_DATA_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
    localparam int unsigned WP_CYC   = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
    localparam int unsigned REC_CYC  = (WRITE_RECOVERY_CS_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
    localparam int unsigned HOLD_CYC = (WRITE_DATA_HOLD_CS_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
    localparam int unsigned CYC_CYC  = (CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
    localparam int unsigned PD_CYC   = (POWERDOWN_LEAD_TIME_US * 1000000 + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
    localparam int unsigned PU_CYC   = 32'((POWERUP_WAIT_TIME_MS * 64'd1000000000
                                       + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    localparam int unsigned ADDR_W = 24;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 20;

    // Request from the user side
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] byte_address;
        logic [DATA_W-1:0] wdata;
    } nvsp_req_type;

    // Pins toward the memory, all strobes active low
    typedef struct packed {
        logic [ADDR_W-1:0] byte_address;
        logic              chip_select_n;
        logic              output_enable_n;
        logic              write_strobe_n;
        logic [DATA_W-1:0] data_lines_o;
        logic              data_lines_oe;
    } nvsp_pins_type;

endpackage

// File: bench/nvsp_host_checker.sv
// Checker: pin timing and sequencing of the memory port host
module nvsp_host_checker #(
    parameter int unsigned PD_CYCLES = 1,
    parameter int unsigned PU_CYCLES = 1
) (
    input wire logic                    clk,
    input wire logic                    reset,
    input wire logic                    rsp_valid,
    input wire logic                    power_fail,
    input wire nvsp_pkg::nvsp_pins_type pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Short names for the strobes
    wire cs_n  = pins.chip_select_n;
    wire oe_n  = pins.output_enable_n;
    wire we_n  = pins.write_strobe_n;
    wire dq_oe = pins.data_lines_oe;
    int unsigned up_cnt_q;
    // Cycles since reset or supply return, held at zero while supply is low
    always_ff @(posedge clk) begin
        if (reset || power_fail)
            up_cnt_q <= 0;
        else if (up_cnt_q < PU_CYCLES)
            up_cnt_q <= up_cnt_q + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // =========
    // Strobe relations
    no_clash_a: assert property (dq_oe || !we_n |-> oe_n) else $error("bus contention");
    read_sel_a: assert property (!oe_n |-> we_n && !cs_n) else $error("bad read");
    addr_hold_a: assert property (!we_n && !$past(we_n) |-> $stable(pins.byte_address))
        else $error("address moved in write");
    pulse_a: assert property ($fell(we_n) |-> (!we_n && !cs_n)[*8] ##1 (!we_n && !cs_n)[*3])
        else $error("write pulse short");
    setup_a: assert property ($rose(we_n) |-> $past(dq_oe, 6)) else $error("data setup");
    hold_a: assert property ($rose(we_n) |-> (dq_oe && $stable(pins.data_lines_o))[*2])
        else $error("data hold");
    joint_rise_a: assert property ($rose(we_n) |-> $rose(cs_n)) else $error("rise order");
    recover_a: assert property ($rose(we_n) |-> cs_n[*3]) else $error("recovery short");
    access_a: assert property ($fell(oe_n) |-> !oe_n[*8] ##1 !oe_n[*6])
        else $error("read too short");
    fail_park_a: assert property (power_fail && cs_n |=> cs_n) else $error("access in fail");
    pu_wait_a: assert property ($fell(cs_n) |-> up_cnt_q >= PU_CYCLES)
        else $error("access before wait");
    cover property ($rose(we_n));
    cover property ($fell(oe_n) ##[1:20] rsp_valid);
    cover property (power_fail && cs_n);
endmodule

bind nvsp_host nvsp_host_checker #(.PD_CYCLES(PD_CYCLES), .PU_CYCLES(PU_CYCLES)) chk (
    .clk(clk), .reset(reset), .rsp_valid(rsp_valid), .power_fail(power_fail), .pins(pins));

// File: bench/nvsp_mem_model.sv
// Behavioural model of the nonvolatile byte-wide memory
module nvsp_mem_model (
    input wire nvsp_pkg::nvsp_pins_type pins,
    input wire logic                    power_fail,
    input wire logic [7:0]              data_lines,
    input var int unsigned              acc_ns,
    output logic [7:0]                  mem_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cells [int unsigned];
    logic [7:0] last_q = 8'h00;
    // Access decode, inputs ignored while supply is low
    wire rd_en = !power_fail && !pins.chip_select_n && !pins.output_enable_n
                 && pins.write_strobe_n;
    wire wr_en = !power_fail && !pins.chip_select_n && !pins.write_strobe_n;
    // Read after the access delay, else a float pattern
    always @(rd_en or pins.byte_address) begin
        mem_q = ~last_q;
        if (rd_en) begin
            #(acc_ns);
            if (rd_en) begin
                last_q = cells.exists(pins.byte_address) ? cells[pins.byte_address] : 8'h00;
                mem_q = last_q;
            end
        end
    end
    // Store at write end, blocked on supply loss
    always @(negedge wr_en) begin
        if (!power_fail)
            cells[pins.byte_address] = data_lines;
    end
endmodule

// File: bench/nvsp_host_tb.sv
// Testbench: host controller against the memory model
module nvsp_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk = 1'b0;
    logic                    reset = 1'b1;
    logic                    req_valid = 1'b0;
    logic                    power_fail = 1'b0;
    logic                    req_ready, rsp_valid, power_ok;
    logic [7:0]              rsp_rdata, mem_q, data_lines_i;
    nvsp_pkg::nvsp_req_type  req = '0;
    nvsp_pkg::nvsp_pins_type pins;
    int unsigned             acc_ns = 10;
    int                      fail_count = 0, n_checks = 0, seed = 22;
    logic [7:0]              shadow [int unsigned];
    // Wire level of the data bus
    assign data_lines_i = pins.data_lines_oe ? pins.data_lines_o : mem_q;
    nvsp_host #(.PD_CYCLES(8), .PU_CYCLES(20)) uut (.clk(clk), .reset(reset),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .power_fail(power_fail), .power_ok(power_ok), .pins(pins),
        .data_lines_i(data_lines_i));
    nvsp_mem_model model (.pins(pins), .power_fail(power_fail), .data_lines(data_lines_i),
        .acc_ns(acc_ns), .mem_q(mem_q));
    // Clock and watchdog
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
    // =========
    // Expectation and compare tasks
    function automatic logic [7:0] exp_rd(input logic [23:0] a);
        return shadow.exists(a) ? shadow[a] : 8'h00;
    endfunction
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t read %h expected %h", $time, got, exp);
        end
    endtask
    // Cycles from take to answer: read cycle, or padded pulse plus hold and recovery
    function automatic int exp_cyc(input logic wr);
        return wr ? int'(nvsp_pkg::WP_CYC + 1 + nvsp_pkg::HOLD_CYC + nvsp_pkg::REC_CYC)
                  : int'(nvsp_pkg::READ_CYC);
    endfunction
    task automatic check_count(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            fail_count++;
            $display("FAIL %0t cycles %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // One request, optional supply loss pf cycles into it
    task automatic do_req(input logic wr, input logic [23:0] a, input logic [7:0] d, input int pf);
        int n;
        n = 0;
        req = {wr, a, d};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        if (pf > 0) begin
            repeat (pf) @(posedge clk);
            #1 power_fail = 1'b1;
        end
        n = 0;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (pf == 0)
            check_bit(rsp_valid, 1'b1);
        if (pf == 0)
            check_count(n, exp_cyc(wr));
        if (wr && pf == 0)
            shadow[a] = d;
        if (!wr)
            check_byte(rsp_rdata, exp_rd(a));
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // =========
    // Main sequence
    initial begin
        logic [31:0] r;
        repeat (20) @(posedge clk);
        #1 reset = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check_bit(req_ready, 1'b0);
        do_req(1'b0, 24'h000000, 8'h00, 0);
        do_req(1'b1, 24'hffffff, 8'ha5, 0);
        do_req(1'b1, 24'h000000, 8'h5a, 0);
        do_req(1'b0, 24'hffffff, 8'h00, 0);
        acc_ns = 65;
        for (int k = 0; k < 24; k++) begin
            r = $random(seed);
            do_req(r[12], {{20{r[8]}}, r[3:0]}, r[31:24], 0);
        end
        do_req(1'b1, 24'hffffff, 8'h3c, 4);
        repeat (4) @(posedge clk);
        #1;
        check_bit(power_ok, 1'b0);
        check_bit(req_ready, 1'b0);
        power_fail = 1'b0;
        do_req(1'b0, 24'hffffff, 8'h00, 0);
        give_verdict();
    end
endmodule
